// [hdl/bus_request_watchdog.sv]
`timescale 1ns/1ps
module bus_request_watchdog import brw_pkg::*; #(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [15:0] reqAddr,
  input wire logic [15:0] reqData,
  input wire logic svcRequest,
  output logic rspDone,
  output logic [15:0] rspData,
  output logic [7:0] rspException,
  output logic timeoutAction,
  output logic closeConnections
);
  logic rstMeta_r;
  logic rstSync_r;
  brw_state_type state_r;
  brw_state_type stateNxt;
  logic [15:0] timeout_r;
  logic [15:0] config_r;
  logic rspDone_r;
  logic [15:0] rspData_r;
  logic [7:0] rspException_r;
  logic timeoutAction_r;
  logic closeConnections_r;

  brw_count_if cnt();

  // Reset release passes two flops; assertion stays asynchronous
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  // Address decode
  logic hitCmd;
  logic hitTmo;
  logic hitSta;
  logic hitCfg;
  logic wr;
  logic rd;
  assign hitCmd = reqAddr == ADDR_COMMAND;
  assign hitTmo = reqAddr == ADDR_TIMEOUT;
  assign hitSta = reqAddr == ADDR_STATE;
  assign hitCfg = reqAddr == ADDR_CONFIG;
  assign wr = reqValid && reqWrite;
  assign rd = reqValid && !reqWrite;

  // Mode and state flags
  logic simpleMode;
  logic explicitOnly;
  logic noTimeout;
  logic running;
  logic expired;
  assign simpleMode = config_r[CFG_SIMPLE_BIT]; // R19
  assign explicitOnly = config_r[CFG_EXPLICIT_BIT];
  assign noTimeout = state_r == stateNoTimeout;
  assign running = state_r == stateRunning;
  assign expired = state_r == stateExpired;

  // Command legality against state and mode
  logic isStart;
  logic isStop;
  logic isReset;
  logic startBad;
  logic stopBad;
  logic resetBad;
  logic cmdBad;
  assign isStart = reqData == CMD_START;
  assign isStop = reqData == CMD_STOP;
  assign isReset = reqData == CMD_RESET;
  assign startBad = noTimeout || (expired && !simpleMode); // R2 R11
  assign stopBad = simpleMode || noTimeout || expired; // R5 R6 R7
  assign resetBad = !(expired && !simpleMode); // R8 R9
  // Unknown values are refused too; in simple mode only start survives
  assign cmdBad = isStart ? startBad : isStop ? stopBad : isReset ? resetBad : 1'b1; // R20

  // Running or expired locks the timeout; config only in advanced mode
  logic tmoLocked;
  logic cfgLocked;
  assign tmoLocked = running || expired; // R12
  assign cfgLocked = !simpleMode && (running || expired);

  // Exception code, first match wins
  logic [7:0] excNext;
  assign excNext = !reqValid ? EXC_NONE :
    !(hitCmd || hitTmo || hitSta || hitCfg) ? EXC_ADDRESS :
    (hitCmd && !reqWrite) ? EXC_FUNCTION : // R1
    (hitCmd && cmdBad) ? EXC_VALUE : // R2 R5 R6 R9
    (hitTmo && reqWrite && tmoLocked) ? EXC_FUNCTION : // R12
    (hitSta && reqWrite) ? EXC_FUNCTION :
    (hitCfg && reqWrite && cfgLocked) ? EXC_FUNCTION : EXC_NONE;

  // Accepted actions
  logic reqOk;
  logic startOk;
  logic stopOk;
  logic resetOk;
  logic tmoWrOk;
  logic cfgWrOk;
  logic toAdvanced;
  assign reqOk = reqValid && excNext == EXC_NONE;
  assign startOk = reqOk && wr && hitCmd && isStart;
  assign stopOk = reqOk && wr && hitCmd && isStop;
  assign resetOk = reqOk && wr && hitCmd && isReset;
  assign tmoWrOk = reqOk && wr && hitTmo;
  assign cfgWrOk = reqOk && wr && hitCfg;
  assign toAdvanced = cfgWrOk && simpleMode && !reqData[CFG_SIMPLE_BIT];

  // Trigger: status reads only when enabled, explicit mode only by start
  logic statusTrig;
  logic trigger;
  assign statusTrig = reqOk && rd && hitSta && config_r[CFG_STATUS_TRIG_BIT];
  assign trigger = statusTrig || (explicitOnly ? startOk : // R18 R20
    ((reqOk && !hitSta) || svcRequest)); // R18

  // Watchdog state machine
  always_comb begin
    stateNxt = state_r;
    unique case (state_r)
      stateNoTimeout: begin
        if (tmoWrOk && reqData != TIMEOUT_RESET) begin // R14
          stateNxt = simpleMode ? stateRunning : stateStopped; // R15
        end
      end
      stateStopped: begin
        if (tmoWrOk && reqData == TIMEOUT_RESET) begin
          stateNxt = stateNoTimeout; // R11
        end else if (startOk || simpleMode) begin
          stateNxt = stateRunning; // R3 R15
        end
      end
      stateRunning: begin
        if (stopOk || toAdvanced) begin
          stateNxt = stateStopped; // R4
        end else if (cnt.elapsed && !trigger) begin
          stateNxt = stateExpired; // R16
        end
      end
      stateExpired: begin
        if (resetOk || toAdvanced) begin
          stateNxt = stateStopped; // R8
        end else if (simpleMode && trigger) begin
          stateNxt = stateRunning; // R17
        end
      end
    endcase
  end

  // Counter control; fresh count on entry to running or on a trigger while it stays running
  logic [15:0] timeoutNxt;
  assign timeoutNxt = tmoWrOk ? reqData : timeout_r;
  assign cnt.run = running; // R4 R16
  assign cnt.loadValue = timeoutNxt;
  assign cnt.restart = stateNxt == stateRunning && (!running || trigger); // R3 R17 R18

  brw_ms_counter #(
    .TICK_LEN(TICK_LEN)
  ) brw_ms_counter_inst (
    .clock(clock),
    .rstSyncN(rstSync_r),
    .cnt(cnt)
  );

  // Read data mux; the command register reads as zero
  logic [15:0] readNext;
  assign readNext = !rd ? 16'h0000 :
    hitTmo ? timeout_r :
    hitSta ? brw_state_code(state_r) : // R13
    hitCfg ? config_r : 16'h0000; // R1

  // State and registers
  always_ff @(posedge clock or negedge rstSync_r) begin
    if (!rstSync_r) begin
      state_r <= stateNoTimeout;
      timeout_r <= TIMEOUT_RESET; // R10
      config_r <= CONFIG_RESET;
    end else begin
      state_r <= stateNxt;
      timeout_r <= timeoutNxt; // R10
      if (cfgWrOk) begin
        config_r <= reqData & CONFIG_MASK; // R19
      end
    end
  end

  // Answer one cycle after each request; timeout action as a pulse
  always_ff @(posedge clock or negedge rstSync_r) begin
    if (!rstSync_r) begin
      rspDone_r <= 1'b0;
      rspData_r <= 16'h0000;
      rspException_r <= EXC_NONE;
      timeoutAction_r <= 1'b0;
      closeConnections_r <= 1'b0;
    end else begin
      rspDone_r <= reqValid;
      rspData_r <= readNext;
      rspException_r <= excNext;
      timeoutAction_r <= running && stateNxt == stateExpired; // R21
      closeConnections_r <= running && stateNxt == stateExpired && config_r[CFG_CLOSE_BIT];
    end
  end

  assign rspDone = rspDone_r;
  assign rspData = rspData_r;
  assign rspException = rspException_r;
  assign timeoutAction = timeoutAction_r;
  assign closeConnections = closeConnections_r;

  default clocking dc @(posedge clock); endclocking
  default disable iff (!rstSync_r);

  a_cmd_no_read: assert property (rd && hitCmd // R1
    |=> rspException_r == EXC_FUNCTION && rspData_r == 16'h0000)
    else $error("command register answered a read");
  a_start_refused: assert property (wr && hitCmd && isStart && startBad // R2
    |=> rspException_r == EXC_VALUE && state_r != stateRunning)
    else $error("bad start not refused");
  a_start_runs: assert property (startOk |=> state_r == stateRunning) // R3
    else $error("accepted start did not run");
  a_stop_halts: assert property (stopOk && running |=> state_r == stateStopped) // R4
    else $error("stop did not halt");
  a_simple_stop: assert property (wr && hitCmd && isStop && simpleMode // R5
    |=> rspException_r == EXC_VALUE && state_r != stateStopped)
    else $error("stop accepted in simple mode");
  a_stop_refused: assert property (wr && hitCmd && isStop && (noTimeout || expired) // R6
    |=> rspException_r == EXC_VALUE && state_r == $past(state_r))
    else $error("stop accepted while unconfigured or expired");
  a_stop_repeat: assert property (wr && hitCmd && isStop && !simpleMode // R7
    && state_r == stateStopped |=> rspException_r == EXC_NONE && state_r == stateStopped)
    else $error("repeated stop misbehaved");
  a_reset_expired: assert property (wr && hitCmd && isReset && expired && !simpleMode // R8
    |=> state_r == stateStopped && rspException_r == EXC_NONE)
    else $error("reset did not stop expired watchdog");
  a_reset_refused: assert property (wr && hitCmd && isReset && !(expired && !simpleMode) // R9
    |=> rspException_r == EXC_VALUE)
    else $error("reset accepted outside expired advanced");
  a_zero_unconf: assert property ((timeout_r == 16'h0000) == noTimeout) // R11
    else $error("zero timeout and unconfigured state disagree");
  a_tmo_locked: assert property (wr && hitTmo && (running || expired) // R12
    |=> rspException_r == EXC_FUNCTION && $stable(timeout_r))
    else $error("timeout write accepted while active");
  a_state_code: assert property (rd && hitSta // R13
    |=> rspData_r == brw_state_code($past(state_r)))
    else $error("state register code wrong");
  a_leave_unconf: assert property (noTimeout && !(tmoWrOk && reqData != 16'h0000) // R14
    |=> noTimeout)
    else $error("left unconfigured without a timeout write");
  a_simple_autorun: assert property (state_r == stateStopped && simpleMode // R15
    && !(tmoWrOk && reqData == 16'h0000) |=> state_r == stateRunning)
    else $error("simple mode rested in stopped");
  a_expire_action: assert property (running && cnt.elapsed && !trigger // R16 R21
    && !stopOk && !toAdvanced |=> expired && timeoutAction_r)
    else $error("elapse did not expire");
  a_simple_rerun: assert property (expired && simpleMode && trigger && !toAdvanced // R17
    |=> running)
    else $error("simple expired watchdog not rerun by trigger");
  a_svc_trigger: assert property (running && svcRequest && !explicitOnly // R18
    && stateNxt == stateRunning |-> cnt.restart)
    else $error("service request did not restart count");
  a_mode_bit: assert property (cfgWrOk |=> simpleMode == $past(reqData[CFG_SIMPLE_BIT])) // R19
    else $error("mode bit not taken from config write");
  a_simple_only_start: assert property (wr && hitCmd && simpleMode && !isStart // R20
    |=> rspException_r == EXC_VALUE)
    else $error("non-start command accepted in simple mode");
  a_action_pulse: assert property (timeoutAction_r |-> expired) // R21
    else $error("timeout action without expiry");

  // Register storage, triggers and the response pulses
  a_tmo_write: assert property (tmoWrOk // R10
    |=> timeout_r == $past(reqData))
    else $error("accepted timeout write not stored");
  a_tmo_readback: assert property (rd && hitTmo // R10
    |=> rspData_r == $past(timeout_r) && rspException_r == EXC_NONE)
    else $error("timeout read returned wrong answer");
  a_close_pulse: assert property (closeConnections_r // R21
    |-> timeoutAction_r && $past(config_r[CFG_CLOSE_BIT]))
    else $error("close pulse without enabled expiry");
  a_refused_no_trig: assert property (running && reqValid && excNext != EXC_NONE // R18
    && !svcRequest |-> !cnt.restart)
    else $error("refused request restarted the count");
  a_explicit_only: assert property (running && explicitOnly && !startOk // R18
    && !statusTrig |-> !cnt.restart)
    else $error("explicit mode restarted without start");
  a_trig_restart: assert property (running && trigger // R18
    && stateNxt == stateRunning |-> cnt.restart)
    else $error("trigger did not restart the count");
  a_expire_from_run: assert property (!expired ##1 expired // R16
    |-> $past(running))
    else $error("expired entered from a non-running state");
  a_no_expire_idle: assert property (!running // R4
    |=> !timeoutAction_r)
    else $error("timeout action while not running");
  a_state_read_ok: assert property (rd && hitSta // R13
    |=> rspException_r == EXC_NONE)
    else $error("state register read refused");
  a_simple_no_rest: assert property (simpleMode && state_r == stateStopped // R15
    |=> state_r != stateStopped)
    else $error("simple mode stayed in stopped");
endmodule

// [hdl/brw_pkg.sv]
// Summary of operation
// [R1] The command register cannot be read back; a read never returns the last command.
// [R2] Start is refused with code 0x03 when unconfigured or expired in advanced mode.
// [R3] A start that is not refused restarts the timeout and enters running.
// [R4] Stop while running in advanced mode halts the count and enters stopped.
// [R5] Any stop in simple mode is refused with 0x03, state unchanged.
// [R6] Stop is also refused with 0x03 when unconfigured or expired in advanced mode.
// [R7] Repeated stops while stopped are accepted silently and change nothing.
// [R8] Reset in expired under advanced mode returns the watchdog to stopped.
// [R9] Reset in any other state or mode is refused with 0x03.
// [R10] Timeout register is unsigned 16 bits in 1 ms steps, zero after reset.
// [R11] A zero timeout means unconfigured and the watchdog cannot start.
// [R12] Timeout writes only in unconfigured or stopped; otherwise refused with 0x01.
// [R13] State register reads 0xFFFF, 0x0000, 0x0001 or 0x0002 by state.
// [R14] Unconfigured is left only by writing a nonzero timeout.
// [R15] Simple mode never rests in stopped; nonzero timeout runs automatically.
// [R16] Running counts the timeout and enters expired when it elapses untriggered.
// [R17] In simple mode an expired watchdog reruns on the next trigger.
// [R18] Every valid master request counts as a trigger restarting the timeout; the code needs config bit 1 for state reads, bit 0 drops all else but start.
// [R19] Config bit 7 selects mode: 0 advanced, 1 simple.
// [R20] In simple mode only the start command is accepted, acting as trigger.
// [R21] An untriggered timeout while running fires the timeout response action.
// [R22] A prescaler makes a 1 ms tick; the count drops once per tick while running.
package brw_pkg;
  localparam logic [15:0] ADDR_COMMAND = 16'hfa00;
  localparam logic [15:0] ADDR_TIMEOUT = 16'hfa01;
  localparam logic [15:0] ADDR_STATE = 16'hfa02;
  localparam logic [15:0] ADDR_CONFIG = 16'hfa03;
  localparam logic [15:0] CMD_START = 16'h5555;
  localparam logic [15:0] CMD_STOP = 16'h55aa;
  localparam logic [15:0] CMD_RESET = 16'haaaa;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNCTION = 8'h01;
  localparam logic [7:0] EXC_ADDRESS = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [15:0] CODE_NO_TIMEOUT = 16'hffff;
  localparam logic [15:0] CODE_STOPPED = 16'h0000;
  localparam logic [15:0] CODE_RUNNING = 16'h0001;
  localparam logic [15:0] CODE_EXPIRED = 16'h0002;
  localparam logic [15:0] TIMEOUT_RESET = 16'h0000;
  localparam logic [15:0] CONFIG_RESET = 16'h0004;
  localparam logic [15:0] CONFIG_MASK = 16'h0087;
  localparam int CFG_EXPLICIT_BIT = 0;
  localparam int CFG_STATUS_TRIG_BIT = 1;
  localparam int CFG_CLOSE_BIT = 2;
  localparam int CFG_SIMPLE_BIT = 7;
  localparam int CLOCK_PERIOD_NS = 5;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLOCK_PERIOD_NS;

  typedef enum logic [1:0] {
    stateNoTimeout,
    stateStopped,
    stateRunning,
    stateExpired
  } brw_state_type;

  // Code shown in the state register
  function automatic logic [15:0] brw_state_code(input brw_state_type s);
    logic [15:0] c;
    c = CODE_NO_TIMEOUT;
    unique case (s)
      stateNoTimeout: c = CODE_NO_TIMEOUT;
      stateStopped: c = CODE_STOPPED;
      stateRunning: c = CODE_RUNNING;
      stateExpired: c = CODE_EXPIRED;
    endcase
    return c;
  endfunction
endpackage

// [hdl/brw_count_if.sv]
`timescale 1ns/1ps
interface brw_count_if;
  logic restart;
  logic run;
  logic [15:0] loadValue;
  logic elapsed;
  modport ctrl(output restart, output run, output loadValue, input elapsed);
  modport counter(input restart, input run, input loadValue, output elapsed);
endinterface

// [hdl/brw_ms_counter.sv]
`timescale 1ns/1ps
module brw_ms_counter import brw_pkg::*; #(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rstSyncN,
  brw_count_if.counter cnt
);
  localparam int PRE_W = $clog2(TICK_LEN + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_LEN - 1);

  logic [PRE_W-1:0] preCount_r;
  logic [15:0] msLeft_r;
  logic tick;

  // One tick per millisecond of running time
  assign tick = cnt.run && preCount_r == PRE_LAST; // R22
  assign cnt.elapsed = tick && !cnt.restart && msLeft_r == 16'h0001; // R16

  // Restart clears the prescaler too, so the first period is a full millisecond
  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      preCount_r <= '0;
      msLeft_r <= 16'h0000;
    end else if (cnt.restart) begin
      preCount_r <= '0;
      msLeft_r <= cnt.loadValue;
    end else if (cnt.run) begin
      preCount_r <= tick ? '0 : preCount_r + PRE_W'(1);
      if (tick && msLeft_r != 16'h0000) begin
        msLeft_r <= msLeft_r - 16'h0001; // R22
      end
    end
  end

  default clocking dc @(posedge clock); endclocking
  default disable iff (!rstSyncN);

  a_ms_step: assert property (tick && !cnt.restart && msLeft_r != 16'h0000 // R22
    |=> msLeft_r == $past(msLeft_r) - 16'h0001)
    else $error("millisecond count did not step down on tick");
  a_ms_hold: assert property (!cnt.run && !cnt.restart |=> $stable(msLeft_r)) // R22
    else $error("millisecond count moved while halted");
endmodule

// [bench/brw_master_model.sv]
`timescale 1ns/1ps
module brw_master_model (
  input wire logic clock,
  input wire logic rspDone,
  input wire logic [15:0] rspData,
  input wire logic [7:0] rspException,
  output logic reqValid,
  output logic reqWrite,
  output logic [15:0] reqAddr,
  output logic [15:0] reqData
);
  // Idle bus at time zero
  initial begin
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqAddr = 16'h0000;
    reqData = 16'h0000;
  end

  // One strobe cycle, then a bounded wait for the answer
  task automatic request(input logic wr, input logic [15:0] addr, input logic [15:0] data,
                         output logic [15:0] rdData, output logic [7:0] exc, output logic ok);
    int n;
    ok = 1'b0;
    rdData = 16'h0000;
    exc = 8'h00;
    @(posedge clock);
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqAddr <= addr;
    reqData <= data;
    @(posedge clock);
    reqValid <= 1'b0;
    // Released lines show the inverse, so a stale sample never looks right
    reqWrite <= ~wr;
    reqAddr <= ~addr;
    reqData <= ~data;
    for (n = 0; n < 4 && !ok; n++) begin
      #1;
      if (rspDone === 1'b1) begin
        ok = 1'b1;
        rdData = rspData;
        exc = rspException;
      end else begin
        @(posedge clock);
      end
    end
  endtask
endmodule

// [bench/test_bus_request_watchdog.sv]
`timescale 1ns/1ps
module test_bus_request_watchdog import brw_pkg::*; ;
  localparam int TL = 4;
  logic clock;
  logic rstn;
  logic svcRequest;
  logic reqValid;
  logic reqWrite;
  logic [15:0] reqAddr;
  logic [15:0] reqData;
  logic rspDone;
  logic [15:0] rspData;
  logic [7:0] rspException;
  logic timeoutAction;
  logic closeConnections;
  int n_mismatch;
  int checks_done;

  // Short prescaler keeps each expiry to a few dozen cycles
  bus_request_watchdog #(.TICK_LEN(TL)) bus_request_watchdog_inst (
    .clock(clock), .rstn(rstn), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqAddr(reqAddr), .reqData(reqData), .svcRequest(svcRequest), .rspDone(rspDone),
    .rspData(rspData), .rspException(rspException), .timeoutAction(timeoutAction),
    .closeConnections(closeConnections)
  );

  brw_master_model brw_master_model_inst (
    .clock(clock), .rspDone(rspDone), .rspData(rspData), .rspException(rspException),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData)
  );

  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic end_of_test();
    $display("TB: %0d checks, %0d mismatches", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // For reads, data carries the expected read value
  task automatic acc(input logic wr, input logic [15:0] addr, input logic [15:0] data,
                     input logic [7:0] expExc);
    logic [15:0] rd;
    logic [7:0] ex;
    logic ok;
    brw_master_model_inst.request(wr, addr, data, rd, ex, ok);
    if (!ok) begin
      n_mismatch++;
      $display("CHECK FAILED rspDone expected 1 seen 0");
      end_of_test();
    end
    check("rspException", {8'h00, expExc}, {8'h00, ex});
    if (!wr) begin
      check("rspData", data, rd);
    end
  endtask

  task automatic sendCmd(input logic [15:0] c, input logic [7:0] e);
    acc(1'b1, ADDR_COMMAND, c, e);
  endtask

  task automatic readState(input logic [15:0] code);
    acc(1'b0, ADDR_STATE, code, EXC_NONE);
  endtask

  task automatic writeTimeout(input logic [15:0] v, input logic [7:0] e);
    acc(1'b1, ADDR_TIMEOUT, v, e);
  endtask

  // Expected count is the timeout times TL cycles less the cycles spent since the last trigger
  task automatic waitExpiry(input int expN, input logic expClose);
    int n;
    logic hit;
    hit = 1'b0;
    for (n = 0; n < 200 && !hit; n++) begin
      @(posedge clock);
      #1;
      hit = (timeoutAction === 1'b1);
      if (hit) begin
        check("closeConnections", {15'h0000, expClose}, {15'h0000, closeConnections});
      end
    end
    if (!hit) begin
      n_mismatch++;
      $display("CHECK FAILED timeoutAction expected 1 seen 0");
      end_of_test();
    end
    check("expiryCycles", 16'(expN), 16'(n));
    // The action is a single-cycle pulse
    @(posedge clock);
    #1;
    check("timeoutAction", 16'h0000, {15'h0000, timeoutAction});
  endtask

  // Main sequence
  initial begin
    n_mismatch = 0;
    checks_done = 0;
    rstn = 1'b0;
    svcRequest = 1'b0;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    readState(CODE_NO_TIMEOUT);
    acc(1'b0, ADDR_TIMEOUT, TIMEOUT_RESET, EXC_NONE);
    acc(1'b0, ADDR_CONFIG, CONFIG_RESET, EXC_NONE);
    sendCmd(CMD_START, EXC_VALUE);
    sendCmd(CMD_STOP, EXC_VALUE);
    sendCmd(CMD_RESET, EXC_VALUE);
    readState(CODE_NO_TIMEOUT);
    acc(1'b0, ADDR_COMMAND, 16'h0000, EXC_FUNCTION);
    acc(1'b0, 16'hfa05, 16'h0000, EXC_ADDRESS);
    writeTimeout(16'hffff, EXC_NONE);
    acc(1'b0, ADDR_TIMEOUT, 16'hffff, EXC_NONE);
    readState(CODE_STOPPED);
    writeTimeout(16'h0003, EXC_NONE);
    sendCmd(CMD_STOP, EXC_NONE);
    sendCmd(CMD_STOP, EXC_NONE);
    readState(CODE_STOPPED);
    sendCmd(CMD_START, EXC_NONE);
    readState(CODE_RUNNING);
    sendCmd(CMD_START, EXC_NONE);
    writeTimeout(16'h0005, EXC_FUNCTION);
    acc(1'b1, ADDR_CONFIG, 16'h0084, EXC_FUNCTION);
    acc(1'b1, ADDR_STATE, 16'h0000, EXC_FUNCTION);
    sendCmd(CMD_STOP, EXC_NONE);
    // A stopped count must never run out
    repeat (30) @(posedge clock);
    readState(CODE_STOPPED);
    sendCmd(CMD_START, EXC_NONE);
    waitExpiry(3 * TL, 1'b1);
    readState(CODE_EXPIRED);
    sendCmd(CMD_START, EXC_VALUE);
    sendCmd(CMD_STOP, EXC_VALUE);
    writeTimeout(16'h0003, EXC_FUNCTION);
    sendCmd(CMD_RESET, EXC_NONE);
    readState(CODE_STOPPED);
    sendCmd(CMD_RESET, EXC_VALUE);
    sendCmd(CMD_START, EXC_NONE);
    // Other services keep the count alive, spaced well under the timeout
    repeat (5) begin
      repeat (5) @(posedge clock);
      svcRequest <= 1'b1;
      @(posedge clock);
      svcRequest <= 1'b0;
    end
    readState(CODE_RUNNING);
    waitExpiry(3 * TL - 2, 1'b1);
    sendCmd(CMD_RESET, EXC_NONE);
    // Explicit mode: only start feeds the count; status reads feed it when enabled
    acc(1'b1, ADDR_CONFIG, 16'h0003, EXC_NONE);
    sendCmd(CMD_START, EXC_NONE);
    acc(1'b0, ADDR_TIMEOUT, 16'h0003, EXC_NONE);
    @(posedge clock);
    svcRequest <= 1'b1;
    @(posedge clock);
    svcRequest <= 1'b0;
    waitExpiry(3 * TL - 4, 1'b0);
    sendCmd(CMD_RESET, EXC_NONE);
    sendCmd(CMD_START, EXC_NONE);
    repeat (4) readState(CODE_RUNNING);
    waitExpiry(3 * TL, 1'b0);
    sendCmd(CMD_RESET, EXC_NONE);
    writeTimeout(16'h0008, EXC_NONE);
    acc(1'b1, ADDR_CONFIG, 16'h0084, EXC_NONE);
    repeat (3) @(posedge clock);
    readState(CODE_RUNNING);
    sendCmd(CMD_STOP, EXC_VALUE);
    sendCmd(CMD_RESET, EXC_VALUE);
    sendCmd(16'h1234, EXC_VALUE);
    readState(CODE_RUNNING);
    waitExpiry(8 * TL - 12, 1'b1);
    sendCmd(CMD_STOP, EXC_VALUE);
    readState(CODE_EXPIRED);
    sendCmd(CMD_START, EXC_NONE);
    readState(CODE_RUNNING);
    acc(1'b1, ADDR_CONFIG, 16'h0004, EXC_NONE);
    readState(CODE_STOPPED);
    writeTimeout(16'h0000, EXC_NONE);
    readState(CODE_NO_TIMEOUT);
    end_of_test();
  end
endmodule
